/* File: rtl/sct_cfg.svh */
// Register map, field positions and reset values of the timer output stage
`ifndef SCT_CFG_SVH
`define SCT_CFG_SVH
// ****************
// Register offsets
// ****************
`define SCT_OFF_CCTRL 8'h00
`define SCT_OFF_COUNT 8'h04
`define SCT_OFF_DIV 8'h08
`define SCT_OFF_PERIOD 8'h0c
`define SCT_OFF_BRK 8'h10
`define SCT_OFF_CFG 8'h14
// ****************
// Field positions
// ****************
`define SCT_CC_EN 0
`define SCT_CC_POL 1
`define SCT_CC_CEN 2
`define SCT_CC_CPOL 3
`define SCT_CC_W 4
`define SCT_BRK_MOE 15
`define SCT_BRK_AOE 14
`define SCT_BRK_IDLE 11
`define SCT_BRK_RUN 10
`define SCT_BRK_DT_HI 7
`define SCT_CFG_IN 0
`define SCT_CFG_MIDLE 1
`define SCT_CFG_CIDLE 2
// ****************
// Reset values
// ****************
`define SCT_RST_16 16'h0000
`define SCT_RST_CC 4'h0
`define SCT_RST_DT 8'h00
`endif

/* File: rtl/sct_pkg.sv */
// Types shared by the timer output stage
package sct_pkg;
    // One output pin: level and drive enable
    typedef struct packed {
        logic lvl;
        logic oe;
    } sct_pin_s;
endpackage

/* File: rtl/sct_timer.sv */
// Single channel timer with complementary output stage and APB registers
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "sct_cfg.svh"
module sct_timer #(
    parameter int CW = 16,
    parameter int DW = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic rawReference,
    input wire logic chInput,
    output var sct_pkg::sct_pin_s chMainOut,
    output var sct_pkg::sct_pin_s chCompOut,
    output logic chTrigger,
    output logic chCaptureEvent,
    output logic overflowEvent
);
    import sct_pkg::*;

    // ****************
    // Register state
    // ****************
    logic [`SCT_CC_W-1:0] cctrl_q; // Channel control bits
    logic [CW-1:0] cnt_q; // Counter value
    logic [CW-1:0] div_q; // Divider as written
    logic [CW-1:0] divAct_q; // Active prescaler value
    logic [CW-1:0] psc_q; // Prescaler count
    logic [CW-1:0] periodVal_q; // Period value
    logic moe_q; // Master output enable
    logic aoe_q; // Automatic master enable
    logic idleSel_q; // Idle off-state select
    logic runSel_q; // Run off-state select
    logic [DW-1:0] dt_q; // Dead-time count
    logic inMode_q; // Channel in input mode
    logic mainIdle_q; // Main idle level
    logic compIdle_q; // Complementary idle level

    // ****************
    // Bus decode
    // ****************
    logic acc; // Access phase, answer pending
    logic wrDone; // Write commits this edge
    logic mapped; // Address hits a register
    logic [31:0] rdMux; // Read data for address
    logic tick; // Prescaled counter clock
    logic ovf; // Overflow this cycle

    assign acc = psel && penable && !pready;
    assign wrDone = psel && penable && pready && pwrite && !pslverr;

    // Read multiplexer and address check
    always_comb
    begin
        rdMux = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            `SCT_OFF_CCTRL: rdMux[`SCT_CC_W-1:0] = cctrl_q;
            `SCT_OFF_COUNT: rdMux[CW-1:0] = cnt_q;
            `SCT_OFF_DIV: rdMux[CW-1:0] = div_q;
            `SCT_OFF_PERIOD: rdMux[CW-1:0] = periodVal_q;
            `SCT_OFF_BRK:
            begin
                rdMux[`SCT_BRK_MOE] = moe_q;
                rdMux[`SCT_BRK_AOE] = aoe_q;
                rdMux[`SCT_BRK_IDLE] = idleSel_q;
                rdMux[`SCT_BRK_RUN] = runSel_q;
                rdMux[DW-1:0] = dt_q;
            end
            `SCT_OFF_CFG:
            begin
                rdMux[`SCT_CFG_IN] = inMode_q;
                rdMux[`SCT_CFG_MIDLE] = mainIdle_q;
                rdMux[`SCT_CFG_CIDLE] = compIdle_q;
            end
            default: mapped = 1'b0;
        endcase
    end

    // APB answer: one wait state, then ready for one cycle
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (acc)
        begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : rdMux;
            pslverr <= !mapped;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Control registers written by software
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cctrl_q <= `SCT_RST_CC;
            div_q <= `SCT_RST_16;
            periodVal_q <= `SCT_RST_16;
            aoe_q <= 1'b0;
            idleSel_q <= 1'b0;
            runSel_q <= 1'b0;
            dt_q <= `SCT_RST_DT;
            inMode_q <= 1'b0;
            mainIdle_q <= 1'b0;
            compIdle_q <= 1'b0;
        end
        else if (wrDone)
        begin
            case (paddr)
                // Upper control bits are not stored and read as zero
                `SCT_OFF_CCTRL: cctrl_q <= pwdata[`SCT_CC_W-1:0];
                `SCT_OFF_DIV: div_q <= pwdata[CW-1:0];
                `SCT_OFF_PERIOD: periodVal_q <= pwdata[CW-1:0];
                `SCT_OFF_BRK:
                begin
                    aoe_q <= pwdata[`SCT_BRK_AOE];
                    idleSel_q <= pwdata[`SCT_BRK_IDLE];
                    runSel_q <= pwdata[`SCT_BRK_RUN];
                    dt_q <= pwdata[DW-1:0];
                end
                `SCT_OFF_CFG:
                begin
                    inMode_q <= pwdata[`SCT_CFG_IN];
                    mainIdle_q <= pwdata[`SCT_CFG_MIDLE];
                    compIdle_q <= pwdata[`SCT_CFG_CIDLE];
                end
                default:
                begin
                    inMode_q <= inMode_q;
                end
            endcase
        end
    end

    // Master output enable: overflow set wins over software clear
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            moe_q <= 1'b0;
        else if (aoe_q && ovf)
            moe_q <= 1'b1;
        else if (wrDone && paddr == `SCT_OFF_BRK)
            moe_q <= pwdata[`SCT_BRK_MOE];
    end

    // ****************
    // Prescaler and counter
    // ****************
    // divide by divider plus one
    assign tick = (psc_q == divAct_q);
    assign ovf = tick && (periodVal_q != `SCT_RST_16) && (cnt_q == periodVal_q);

    // Prescaler count and active divider
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            psc_q <= `SCT_RST_16;
            divAct_q <= `SCT_RST_16;
        end
        else
        begin
            psc_q <= tick ? `SCT_RST_16 : psc_q + 1'b1;
            if (ovf)
                divAct_q <= div_q;
        end
    end

    // Counter value, also writable by software
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            cnt_q <= `SCT_RST_16;
        else if (wrDone && paddr == `SCT_OFF_COUNT)
            cnt_q <= pwdata[CW-1:0];
        else if (tick && periodVal_q != `SCT_RST_16)
            cnt_q <= ovf ? `SCT_RST_16 : cnt_q + 1'b1;
    end

    // Overflow pulse to the outside
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            overflowEvent <= 1'b0;
        else
            overflowEvent <= ovf;
    end

    // ****************
    // Input path
    // ****************
    logic inSync1_q; // First synchroniser stage
    logic inSync2_q; // Second synchroniser stage
    logic inPrev_q; // Previous synchronised level
    logic inOn; // Input capture enabled

    assign inOn = cctrl_q[`SCT_CC_EN] && inMode_q;

    // Two-stage synchroniser and edge history
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            inSync1_q <= 1'b0;
            inSync2_q <= 1'b0;
            inPrev_q <= 1'b0;
        end
        else
        begin
            inSync1_q <= chInput;
            inSync2_q <= inSync1_q;
            inPrev_q <= inSync2_q;
        end
    end

    // Edge and trigger under polarity control
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            chTrigger <= 1'b0;
            chCaptureEvent <= 1'b0;
        end
        else
        begin
            chTrigger <= inOn && (inSync2_q ^ cctrl_q[`SCT_CC_POL]);
            chCaptureEvent <= inOn && (cctrl_q[`SCT_CC_POL] ?
                (inPrev_q && !inSync2_q) : (!inPrev_q && inSync2_q));
        end
    end

    // ****************
    // Dead-time and idle timing
    // ****************
    logic mainEn; // Main output enabled
    logic compEn; // Complementary output enabled
    logic [1:0] refPair; // Reference per output
    logic [1:0] refPrev_q; // Reference one cycle ago
    logic [DW-1:0] dtCnt_q [2]; // Dead-time down counters
    logic [1:0] dly; // Dead-timed references
    logic [DW-1:0] idleCnt_q; // Time since master disable
    logic idleDone; // Dead-time elapsed in idle

    assign mainEn = cctrl_q[`SCT_CC_EN] && !inMode_q;
    assign compEn = cctrl_q[`SCT_CC_CEN];
    assign refPair = {!rawReference, rawReference};
    assign idleDone = (idleCnt_q >= dt_q);

    // Per-output delay of rising edges
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            refPrev_q <= 2'h0;
            for (int i = 0; i < 2; i++)
                dtCnt_q[i] <= `SCT_RST_DT;
        end
        else
        begin
            refPrev_q <= refPair;
            for (int i = 0; i < 2; i++)
            begin
                if (refPair[i] && !refPrev_q[i])
                    dtCnt_q[i] <= dt_q;
                else if (dtCnt_q[i] != `SCT_RST_DT)
                    dtCnt_q[i] <= dtCnt_q[i] - 1'b1;
            end
        end
    end

    // Delayed reference rises only when its count has run out
    always_comb
    begin
        dly = 2'h0;
        for (int i = 0; i < 2; i++)
            dly[i] = refPair[i] && refPrev_q[i] && (dtCnt_q[i] == `SCT_RST_DT);
    end

    // Idle timer counts while master enable is off
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            idleCnt_q <= `SCT_RST_DT;
        else if (moe_q)
            idleCnt_q <= `SCT_RST_DT;
        else if (!idleDone)
            idleCnt_q <= idleCnt_q + 1'b1;
    end

    // ****************
    // Output state selection
    // ****************
    logic pol; // Main polarity
    logic cpol; // Complementary polarity
    sct_pin_s mainD; // Next main pin state
    sct_pin_s compD; // Next complementary pin state

    assign pol = cctrl_q[`SCT_CC_POL];
    assign cpol = cctrl_q[`SCT_CC_CPOL];

    // Output table by master, off-state selects and enables
    always_comb
    begin
        mainD = '{lvl: 1'b0, oe: 1'b0};
        compD = '{lvl: 1'b0, oe: 1'b0};
        if (moe_q)
        begin
            if (mainEn && compEn)
            begin
                mainD = '{lvl: dly[0] ^ pol, oe: 1'b1};
                compD = '{lvl: dly[1] ^ cpol, oe: 1'b1};
            end
            else
            begin
                if (mainEn)
                    mainD = '{lvl: rawReference ^ pol, oe: 1'b1};
                else
                    mainD = '{lvl: runSel_q && pol, oe: runSel_q && compEn};
                if (compEn)
                    compD = '{lvl: rawReference ^ cpol, oe: 1'b1};
                else
                    compD = '{lvl: runSel_q && cpol, oe: runSel_q && mainEn};
            end
        end
        else if (!idleSel_q)
        begin
            mainD = '{lvl: 1'b0, oe: 1'b0};
            compD = '{lvl: 1'b0, oe: 1'b0};
        end
        else if (!mainEn && !compEn)
        begin
            mainD = '{lvl: pol, oe: 1'b0};
            compD = '{lvl: cpol, oe: 1'b0};
        end
        else
        begin
            mainD = '{lvl: idleDone ? mainIdle_q : pol, oe: 1'b1};
            compD = '{lvl: idleDone ? compIdle_q : cpol, oe: 1'b1};
        end
    end

    // Registered pin drive
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            chMainOut <= '{lvl: 1'b0, oe: 1'b0};
            chCompOut <= '{lvl: 1'b0, oe: 1'b0};
        end
        else
        begin
            chMainOut <= mainD;
            chCompOut <= compD;
        end
    end
endmodule // sct_timer
`default_nettype wire

/* File: tb/sct_timer_assertions.sv */
// Port checks for the timer output stage
`timescale 1ns/10ps
`default_nettype none
module sct_timer_chk #(
    parameter int DW = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic rawReference,
    input wire logic chInput,
    input wire sct_pkg::sct_pin_s chMainOut,
    input wire sct_pkg::sct_pin_s chCompOut,
    input wire logic chTrigger,
    input wire logic chCaptureEvent,
    input wire logic overflowEvent
);
    import sct_pkg::*;
    // ****
    // Shadow of the control writes
    // ****
    logic [3:0] cc_q;
    logic [15:0] brk_q;
    logic [2:0] cfg_q;
    logic [3:0] quiet_q;
    logic wr;
    logic settled;
    logic runOn;
    logic runOff;
    assign wr = psel && penable && pready && pwrite;
    // Settled output mode with no automatic enable
    assign settled = !brk_q[14] && !cfg_q[0] && quiet_q > 4'h3;
    assign runOn = settled && brk_q[15];
    assign runOff = settled && !brk_q[15];
    // Copy committed writes
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cc_q <= 4'h0;
            brk_q <= 16'h0000;
            cfg_q <= 3'h0;
        end
        else if (wr && paddr == 8'h00)
            cc_q <= pwdata[3:0];
        else if (wr && paddr == 8'h10)
            brk_q <= pwdata[15:0];
        else if (wr && paddr == 8'h14)
            cfg_q <= pwdata[2:0];
    end
    // Cycles since the last write, saturating
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || wr)
            quiet_q <= 4'h0;
        else if (quiet_q != 4'hf)
            quiet_q <= quiet_q + 4'h1;
    end
    // ****
    // Properties
    // ****
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_ovf_pulse: assert property (overflowEvent |=> !overflowEvent)
        else $error("overflow pulse too long");
    a_cap_trigger: assert property (chCaptureEvent |-> ##[0:1] chTrigger)
        else $error("capture without trigger level");
    a_main_single: assert property (runOn && cc_q[0] && !cc_q[2]
        |-> chMainOut == {$past(rawReference) ^ cc_q[1], 1'b1}) else $error("main single");
    a_comp_single: assert property (runOn && cc_q[2] && !cc_q[0]
        |-> chCompOut == {$past(rawReference) ^ cc_q[3], 1'b1}) else $error("comp single");
    a_run_offstate: assert property (runOn && brk_q[10] && cc_q[2] && !cc_q[0]
        |-> chMainOut == {cc_q[1], 1'b1}) else $error("main off-state");
    a_idle_float: assert property (runOff && !(brk_q[11] && (cc_q[0] || cc_q[2]))
        |-> !chMainOut.oe && !chCompOut.oe) else $error("idle pins driven");
    a_deadtime_rise: assert property (runOn && cc_q == 4'h5 && brk_q[DW-1:0] != '0
        && $rose(rawReference) |=> !chMainOut.lvl && !chCompOut.lvl) else $error("dead-time");
    a_idle_levels: assert property (runOff && brk_q[11] && (cc_q[0] || cc_q[2])
        && quiet_q == 4'hf && brk_q[DW-1:0] < DW'(8)
        |-> chMainOut == {cfg_q[1], 1'b1} && chCompOut == {cfg_q[2], 1'b1})
        else $error("idle levels");
    c_ovf: cover property (overflowEvent);
    c_cap: cover property (chCaptureEvent);
    c_idle: cover property (runOff && brk_q[11] && quiet_q == 4'hf);
endmodule  // sct_timer_chk
`default_nettype wire

/* File: tb/sct_pin_model.sv */
// Pin-side model: resolves both output pins and drives the input pin
`timescale 1ns/10ps
`default_nettype none
module sct_pin_model (
    input wire logic core_clk,
    input wire sct_pkg::sct_pin_s mainDrv,
    input wire sct_pkg::sct_pin_s compDrv,
    input wire logic inLevel,
    output logic mainPin,
    output logic compPin,
    output logic chInput
);
    import sct_pkg::*;
    // Undriven pins show the inverse of the offered level, so a lost drive shows up
    assign mainPin = mainDrv.oe ? mainDrv.lvl : ~mainDrv.lvl;
    assign compPin = compDrv.oe ? compDrv.lvl : ~compDrv.lvl;
    // External source of the channel input
    assign chInput = inLevel;
endmodule  // sct_pin_model
`default_nettype wire

/* File: tb/sct_timer_tb.sv */
// Self-checking bench for the timer output stage
`timescale 1ns/10ps
`default_nettype none
module sct_timer_tb;
    import sct_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic rawReference = 1'b0;
    logic inLevel = 1'b0;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic chInput;
    logic chTrigger;
    logic chCaptureEvent;
    logic overflowEvent;
    logic mainPin;
    logic compPin;
    sct_pin_s chMainOut;
    sct_pin_s chCompOut;
    int n_errors = 0;
    int cmp_count = 0;
    logic [32:0] expQ[$];
    logic [31:0] lfsr = 32'hf83f4f7c;
    sct_timer sct_timer_inst (.*);
    sct_pin_model sct_pin_model_inst (.core_clk(core_clk), .mainDrv(chMainOut),
        .compDrv(chCompOut), .inLevel(inLevel), .mainPin(mainPin), .compPin(compPin),
        .chInput(chInput));
    initial
    begin
        forever #50 core_clk = ~core_clk;
    end
    // ****
    // Helpers
    // ****
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic summarize;
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; reads note the expected answer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [32:0] e);
        int n;
        if (!w)
            expQ.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do @(posedge core_clk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20)
        begin
            n_errors++;
            summarize();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // Read answers are taken off the queue as they appear
    always @(posedge core_clk)
    begin
        if (psel === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
            chk({pslverr, prdata}, expQ.pop_front());
    end
    task automatic ovf(output int g);
        g = 0;
        do
        begin
            @(posedge core_clk);
            g++;
        end
        while (overflowEvent !== 1'b1 && g < 200);
        if (overflowEvent !== 1'b1)
        begin
            n_errors++;
            summarize();
        end
    endtask
    task automatic cap(input logic l, input logic e);
        int n;
        n = 0;
        inLevel <= l;
        repeat (10)
        begin
            @(posedge core_clk);
            if (chCaptureEvent === 1'b1)
                n++;
        end
        chk(33'(n), 33'(e));
        chk(33'(chTrigger), 33'(e));
    endtask
    // Expected pin state from control, polarity and idle settings
    task automatic pins(input logic [3:0] c, input logic [15:0] b, input logic [2:0] f);
        logic r;
        logic mo;
        logic co;
        logic ml;
        logic cl;
        r = rawReference;
        mo = b[15] ? c[0] | (b[10] & c[2]) : b[11] & (c[0] | c[2]);
        co = b[15] ? c[2] | (b[10] & c[0]) : mo;
        ml = b[15] ? (c[0] ? r ^ c[1] : c[1]) : f[1];
        cl = b[15] ? (c[2] ? r ^ c[0] ^ c[3] : c[3]) : f[2];
        chk(33'({chMainOut.oe, mo & mainPin}), 33'({mo, mo & ml}));
        chk(33'({chCompOut.oe, co & compPin}), 33'({co, co & cl}));
    endtask
    // ****
    // Scenarios
    // ****
    initial
    begin
        int g;
        logic [3:0] c;
        logic [15:0] b;
        logic [2:0] f;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        for (int a = 0; a < 6; a++)
            apb(1'b0, 8'(a * 4), 32'h0, 33'h0);
        apb(1'b0, 8'h20, 32'h0, 33'h1_0000_0000);
        for (int k = 0; k < 128; k++)
        begin
            lfsr = nxt(lfsr);
            c = k[3:0];
            b = {k[6], 3'b000, k[5], k[4], 2'b00, 8'h03};
            f = {lfsr[2:1], 1'b0};
            // unused pair keeps idle and polarity clear
            if (c[0] == 1'b0 && c[2] == 1'b0)
            begin
                c = 4'h0;
                f = 3'h0;
            end
            apb(1'b1, 8'h00, 32'(c), 33'h0);
            apb(1'b0, 8'h00, 32'h0, 33'(c));
            apb(1'b1, 8'h10, 32'(b), 33'h0);
            apb(1'b1, 8'h14, 32'(f), 33'h0);
            repeat (6) @(posedge core_clk);
            rawReference <= lfsr[0];
            repeat (12) @(posedge core_clk);
            pins(c, b, f);
        end
        apb(1'b1, 8'h10, 32'h4000, 33'h0);
        apb(1'b1, 8'h08, 32'h2, 33'h0);
        apb(1'b1, 8'h0c, 32'h3, 33'h0);
        ovf(g);
        chk(33'(g < 8), 33'h1);
        ovf(g);
        chk(33'(g), 33'((3 + 1) * (2 + 1)));
        apb(1'b0, 8'h10, 32'h0, 33'hc000);
        apb(1'b1, 8'h0c, 32'h0, 33'h0);
        apb(1'b1, 8'h04, 32'h5, 33'h0);
        repeat (20) @(posedge core_clk);
        apb(1'b0, 8'h04, 32'h0, 33'h5);
        for (int p = 0; p < 2; p++)
        begin
            inLevel <= p[0];
            apb(1'b1, 8'h14, 32'h1, 33'h0);
            apb(1'b1, 8'h00, 32'(p * 2 + 1), 33'h0);
            cap(~p[0], 1'b1);
            cap(p[0], 1'b0);
        end
        apb(1'b1, 8'h00, 32'h0, 33'h0);
        cap(1'b0, 1'b0);
        summarize();
    end
endmodule  // sct_timer_tb
bind sct_timer sct_timer_chk #(.DW(DW)) sct_timer_chk_inst (.*);
`default_nettype wire
